// >>> design/dpw_pkg.sv
package dpw_pkg;

  // register indices on the plain port
  localparam logic [1:0] REG_CTRL = 2'h0;  // misc_control_write_reg
  localparam logic [1:0] REG_STAT = 2'h1;  // misc_status_read_reg

  // control byte layout
  localparam int CTRL_LOOP = 4;            // local loopback
  localparam int CTRL_ECHO = 3;            // auto echo
  localparam int CMD_LSB   = 5;            // command field low bit
  localparam int CMD_MSB   = 7;            // command field high bit

  // loop commands
  localparam logic [2:0] CMD_SEARCH   = 3'h1;  // enter search mode
  localparam logic [2:0] CMD_RST_MISS = 3'h2;  // reset missing clock
  localparam logic [2:0] CMD_DISABLE  = 3'h3;  // disable loop
  localparam logic [2:0] CMD_SRC_BRG  = 3'h4;  // source = baud generator
  localparam logic [2:0] CMD_SRC_PIN  = 3'h5;  // source = rx_tx_clock_pin
  localparam logic [2:0] CMD_FM       = 3'h6;  // fm mode
  localparam logic [2:0] CMD_NRZI     = 3'h7;  // nrzi mode

  // status byte layout
  localparam int STAT_ONE_MISS = 7;
  localparam int STAT_TWO_MISS = 6;
  localparam int STAT_SRC      = 3;
  localparam int STAT_FM       = 2;
  localparam int STAT_SEARCH   = 1;
  localparam int STAT_EN       = 0;

  // counter positions in half counts: position = 2 * count + half
  localparam logic [5:0] POS_SEARCH  = 6'h20;  // count 16, first half
  localparam logic [5:0] POS_DROP    = 6'h04;  // count 2
  localparam logic [5:0] POS_C5_PRE  = 6'h09;  // last half of count 4
  localparam logic [5:0] POS_C5_LO   = 6'h0a;  // count 5, first half
  localparam logic [5:0] POS_C5_HI   = 6'h0b;  // count 5, second half
  localparam logic [5:0] POS_C6      = 6'h0c;  // count 6
  localparam logic [5:0] POS_WIN_LO  = 6'h19;  // middle of count 12
  localparam logic [5:0] POS_WIN_HI  = 6'h26;  // up to middle of count 19
  localparam logic [5:0] POS_CHECK   = 6'h27;  // window closed
  localparam logic [5:0] POS_LOCK_LO = 6'h1f;  // middle of count 15
  localparam logic [5:0] POS_LOCK_HI = 6'h20;  // up to middle of count 16
  localparam logic [5:0] POS_TX_LAG  = 6'h08;  // quarter of fm clock period
  localparam int         BIT_NRZI_CK = 5;      // count bit 4 in half counts
  localparam int         BIT_FM_CK   = 4;      // count bit 3 in half counts

  // pending count correction
  typedef enum logic [1:0] {ADJ_NONE, ADJ_SHORT, ADJ_LONG} dpw_adj_e;

endpackage

// >>> design/dpw_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for a group of pin levels
module dpw_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);

  typedef struct packed {
    logic [W-1:0] s1;  // first stage, read only by s2
    logic [W-1:0] s2;  // settled copy
  } dpw_sync_s;

  dpw_sync_s st_r;
  dpw_sync_s st_nxt;

  // shift one stage per clock
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d_in;
    st_nxt.s2 = st_r.s1;
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign d_out = st_r.s2;

endmodule // dpw_sync

// >>> design/dpw_diag_mux.sv
`timescale 1ns/1ps
// loopback and echo steering of the serial data path
module dpw_diag_mux (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic loop,       // local loopback
  input  wire logic echo,       // auto echo
  input  wire logic auto_en,    // auto enables selected
  input  wire logic tx_data,    // transmitter output
  input  wire logic rxd_s,      // synchronised receive pin
  input  wire logic cts_s_n,    // synchronised clear-to-send, low active
  input  wire logic dcd_s_n,    // synchronised carrier detect, low active
  output logic      txd_pin,    // transmit pin level
  output logic      rx_data,    // receiver input
  output logic      tx_go,      // transmitter may run
  output logic      rx_go       // receiver may run
);

  typedef struct packed {
    logic txd;
    logic rxd;
    logic txg;
    logic rxg;
  } dpw_mux_s;

  dpw_mux_s st_r;
  dpw_mux_s st_nxt;
  logic     ign_cts;  // clear-to-send not an enable
  logic     ign_dcd;  // carrier detect not an enable

  // path selection; echo outranks loopback
  always_comb begin
    st_nxt  = st_r;
    ign_cts = loop | echo;
    ign_dcd = loop;
    if (echo) begin
      st_nxt.txd = rxd_s;
      st_nxt.rxd = rxd_s;
    end else if (loop) begin
      st_nxt.txd = tx_data;
      st_nxt.rxd = tx_data;
    end else begin
      st_nxt.txd = tx_data;            // normal path
      st_nxt.rxd = rxd_s;
    end
    // enables follow the pins only when auto enables are on
    st_nxt.txg = ~auto_en | ign_cts | ~cts_s_n;
    st_nxt.rxg = ~auto_en | ign_dcd | ~dcd_s_n;
  end

  // idle line is marking, so reset to one
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r     <= '0;
      st_r.txd <= 1'b1;
      st_r.rxd <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign txd_pin = st_r.txd;
  assign rx_data = st_r.rxd;
  assign tx_go   = st_r.txg;
  assign rx_go   = st_r.rxg;

endmodule // dpw_diag_mux

// >>> design/dpw_top.sv
`timescale 1ns/1ps
// receive clock recovery loop with missing-edge watch and diagnostics
module dpw_top (
  input  wire logic       CLK,
  input  wire logic       SRST,
  input  wire logic [1:0] ADDR,                  // register index
  input  wire logic [7:0] WDATA,                 // write data
  input  wire logic       WR,                    // write strobe
  input  wire logic       RD,                    // read strobe
  output logic      [7:0] RDATA,                 // read data, cycle after RD
  input  wire logic       RX_TX_CLOCK_PIN,       // pin clock source
  input  wire logic       BRG_CLK,               // baud generator clock source
  input  wire logic       RXD_PIN,               // receive data pin
  output logic            TXD_PIN,               // transmit data pin
  input  wire logic       TX_DATA,               // transmitter serial output
  output logic            RX_DATA,               // receiver serial input
  input  wire logic       CLEAR_TO_SEND_PIN_N,   // clear to send, low active
  input  wire logic       CARRIER_DETECT_PIN_N,  // carrier_detect_pin, low active
  input  wire logic       AUTO_ENABLES,          // auto enables selected
  output logic            TX_GO,                 // transmitter enable
  output logic            RX_GO,                 // receiver enable
  output logic            RX_CLK,                // recovered receive clock
  output logic            TX_CLK,                // recovered transmit clock
  output logic            RX_SAMPLE              // receive sample pulse
);

  // all state of the block
  typedef struct packed {
    logic               en;         // loop enabled
    logic               search;     // waiting for first edge
    logic               fm;         // fm mode, else nrzi
    logic               src_brg;    // source is baud generator
    logic               loop;       // local loopback bit
    logic               echo;       // auto echo bit
    logic [5:0]         cnt;        // half-count position
    dpw_pkg::dpw_adj_e  act;        // correction in this cycle
    dpw_pkg::dpw_adj_e  pend;       // correction for next cycle
    logic               dbl;        // count five already doubled
    logic               seen;       // edge found in fm window
    logic               miss_prev;  // previous window missed
    logic               drop;       // search entry pending
    logic               one_miss;   // single edge missed
    logic               two_miss;   // two edges missed
    logic               src_prev;   // last source level
    logic               rxd_prev;   // last receive level
    logic               rxclk;      // registered receive clock
    logic               txclk;      // registered transmit clock
    logic               samp;       // receive sample pulse
    logic               rd_v;       // read data phase
    logic [7:0]         rdata;      // read data
  } dpw_top_s;

  dpw_top_s   st_r;
  dpw_top_s   st_nxt;

  logic [4:0] pins_raw;   // external levels before synchronising
  logic [4:0] pins_s;     // synchronised levels
  logic       pin_ck_s;   // synchronised pin clock
  logic       brg_ck_s;   // synchronised baud generator clock
  logic       rxd_s;      // synchronised receive pin
  logic       cts_s_n;    // synchronised clear to send
  logic       dcd_s_n;    // synchronised carrier detect
  logic       src_lvl;    // selected source level
  logic       tick;       // one half count of the loop
  logic       rx_edge;    // transition on receive pin
  logic       wr_ctrl;    // control byte written
  logic [2:0] cmd;        // command field of a control write
  logic [5:0] pos;        // position after this tick
  logic       in_win;     // edge inside fm window
  logic [5:0] tx_pos;     // lagged position for fm transmit clock
  logic [7:0] stat;       // status byte

  // every pin level crosses into the clock domain here
  assign pins_raw = {RX_TX_CLOCK_PIN, BRG_CLK, RXD_PIN,
                     CLEAR_TO_SEND_PIN_N, CARRIER_DETECT_PIN_N};

  dpw_sync #(
    .W     (5)
  ) u_sync (
    .clk   (CLK),
    .srst  (SRST),
    .d_in  (pins_raw),
    .d_out (pins_s)
  );

  assign pin_ck_s = pins_s[4];
  assign brg_ck_s = pins_s[3];
  assign rxd_s    = pins_s[2];
  assign cts_s_n  = pins_s[1];
  assign dcd_s_n  = pins_s[0];

  // data path steering and enables
  dpw_diag_mux u_mux (
    .clk     (CLK),
    .srst    (SRST),
    .loop    (st_r.loop),
    .echo    (st_r.echo),
    .auto_en (AUTO_ENABLES),
    .tx_data (TX_DATA),
    .rxd_s   (rxd_s),
    .cts_s_n (cts_s_n),
    .dcd_s_n (dcd_s_n),
    .txd_pin (TXD_PIN),
    .rx_data (RX_DATA),
    .tx_go   (TX_GO),
    .rx_go   (RX_GO)
  );

  // source mux; changing it while enabled can make short pulses,
  // so software should switch it only with the loop disabled
  assign src_lvl = st_r.src_brg ? brg_ck_s : pin_ck_s;

  // both source edges advance the counter by half a count
  assign tick    = src_lvl ^ st_r.src_prev;

  // the loop always watches the pin, never the receiver input,
  // so it cannot follow data while in local loopback
  assign rx_edge = rxd_s ^ st_r.rxd_prev;

  // command decode
  assign wr_ctrl = WR & (ADDR == dpw_pkg::REG_CTRL);
  assign cmd     = WDATA[dpw_pkg::CMD_MSB:dpw_pkg::CMD_LSB];

  // window test on the position the edge falls in
  assign in_win  = (st_r.cnt >= dpw_pkg::POS_WIN_LO) &&
                   (st_r.cnt <= dpw_pkg::POS_WIN_HI);

  // status byte assembly
  always_comb begin
    stat                        = '0;
    stat[dpw_pkg::STAT_ONE_MISS] = st_r.one_miss;
    stat[dpw_pkg::STAT_TWO_MISS] = st_r.two_miss;
    stat[dpw_pkg::STAT_SRC]      = st_r.src_brg;
    stat[dpw_pkg::STAT_FM]       = st_r.fm;
    stat[dpw_pkg::STAT_SEARCH]   = st_r.search;
    stat[dpw_pkg::STAT_EN]       = st_r.en;
  end

  // next position with count five deleted or doubled
  always_comb begin
    pos = st_r.cnt + 6'h01;
    if (st_r.act == dpw_pkg::ADJ_SHORT && st_r.cnt == dpw_pkg::POS_C5_PRE) begin
      pos = dpw_pkg::POS_C6;
    end else if (st_r.act == dpw_pkg::ADJ_LONG && !st_r.dbl &&
                 st_r.cnt == dpw_pkg::POS_C5_HI) begin
      pos = dpw_pkg::POS_C5_LO;
    end
  end

  // main next-state logic
  always_comb begin
    st_nxt          = st_r;
    st_nxt.src_prev = src_lvl;
    st_nxt.rxd_prev = rxd_s;
    st_nxt.rd_v     = RD;
    st_nxt.rdata    = '0;

    // read data stands only in the cycle after the strobe
    if (RD) begin
      unique case (ADDR)
        dpw_pkg::REG_CTRL: begin
          st_nxt.rdata[dpw_pkg::CTRL_LOOP] = st_r.loop;
          st_nxt.rdata[dpw_pkg::CTRL_ECHO] = st_r.echo;
        end
        dpw_pkg::REG_STAT: begin
          st_nxt.rdata = stat;
        end
        default: begin
          st_nxt.rdata = '0;                    // unmapped reads zero
        end
      endcase
    end

    // counter runs only while enabled and locked
    if (st_r.en && !st_r.search) begin
      // edge handling; first edge sets phase, later ones steer
      if (rx_edge) begin
        if (st_r.fm) begin
          // fm cycle covers two cells; data edges outside the
          // window would otherwise pull the phase
          if (in_win) begin
            st_nxt.seen = 1'b1;
            if (st_r.cnt > dpw_pkg::POS_LOCK_HI) begin
              st_nxt.pend = dpw_pkg::ADJ_LONG;
            end else if (st_r.cnt < dpw_pkg::POS_LOCK_LO) begin
              st_nxt.pend = dpw_pkg::ADJ_SHORT;
            end else begin
              st_nxt.pend = dpw_pkg::ADJ_NONE;
            end
          end
        end else begin
          // nrzi: whole cycle splits at the boundary
          if (st_r.cnt > dpw_pkg::POS_LOCK_HI) begin
            st_nxt.pend = dpw_pkg::ADJ_LONG;
          end else if (st_r.cnt < dpw_pkg::POS_LOCK_LO) begin
            st_nxt.pend = dpw_pkg::ADJ_SHORT;
          end else begin
            st_nxt.pend = dpw_pkg::ADJ_NONE;
          end
        end
      end

      if (tick) begin
        st_nxt.cnt = pos;
        if (st_r.act == dpw_pkg::ADJ_LONG && st_r.cnt == dpw_pkg::POS_C5_HI) begin
          st_nxt.dbl = 1'b1;
        end
        // cycle wrap: load the correction for the new cycle
        if (pos == '0) begin
          st_nxt.act  = st_nxt.pend;
          st_nxt.pend = dpw_pkg::ADJ_NONE;
          st_nxt.dbl  = 1'b0;
          st_nxt.seen = 1'b0;
        end
        // fm window closed: judge the cycle
        if (st_r.fm && pos == dpw_pkg::POS_CHECK) begin
          if (st_nxt.seen) begin
            st_nxt.miss_prev = 1'b0;
          end else if (st_r.miss_prev) begin
            st_nxt.two_miss = 1'b1;
            st_nxt.drop     = 1'b1;
          end else begin
            // one miss only flags; no correction follows since
            // no edge was taken in this cycle
            st_nxt.one_miss  = 1'b1;
            st_nxt.miss_prev = 1'b1;
          end
        end
        // drop into search where both clocks are low
        if (st_r.drop && pos == dpw_pkg::POS_DROP) begin
          st_nxt.search    = 1'b1;
          st_nxt.cnt       = dpw_pkg::POS_SEARCH;
          st_nxt.drop      = 1'b0;
          st_nxt.miss_prev = 1'b0;
          st_nxt.act       = dpw_pkg::ADJ_NONE;
          st_nxt.pend      = dpw_pkg::ADJ_NONE;
        end
      end
    end else if (st_r.en && st_r.search && rx_edge) begin
      // first edge taken as a cell boundary; counter held at 16
      st_nxt.search    = 1'b0;
      st_nxt.cnt       = dpw_pkg::POS_SEARCH;
      st_nxt.seen      = 1'b1;
      st_nxt.miss_prev = 1'b0;
      st_nxt.act       = dpw_pkg::ADJ_NONE;
      st_nxt.pend      = dpw_pkg::ADJ_NONE;
      st_nxt.dbl       = 1'b0;
    end

    // software commands; a miss in the same cycle still sets, except under disable or nrzi
    if (wr_ctrl) begin
      st_nxt.loop = WDATA[dpw_pkg::CTRL_LOOP];
      st_nxt.echo = WDATA[dpw_pkg::CTRL_ECHO];
      unique case (cmd)
        dpw_pkg::CMD_SEARCH: begin
          // enables a held loop or restarts a running one
          st_nxt.en        = 1'b1;
          st_nxt.search    = 1'b1;
          st_nxt.cnt       = dpw_pkg::POS_SEARCH;
          st_nxt.drop      = 1'b0;
          st_nxt.miss_prev = 1'b0;
          st_nxt.act       = dpw_pkg::ADJ_NONE;
          st_nxt.pend      = dpw_pkg::ADJ_NONE;
          st_nxt.one_miss  = st_nxt.one_miss & st_r.en & ~st_r.search &
                             ~st_r.one_miss;
          st_nxt.two_miss  = st_nxt.two_miss & ~st_r.two_miss;
        end
        dpw_pkg::CMD_RST_MISS: begin
          st_nxt.one_miss = st_nxt.one_miss & ~st_r.one_miss;
          st_nxt.two_miss = st_nxt.two_miss & ~st_r.two_miss;
        end
        dpw_pkg::CMD_DISABLE: begin
          st_nxt.en     = 1'b0;
          st_nxt.search = 1'b1;
          st_nxt.cnt    = dpw_pkg::POS_SEARCH;
          st_nxt.drop   = 1'b0;
        end
        dpw_pkg::CMD_SRC_BRG: st_nxt.src_brg = 1'b1;
        dpw_pkg::CMD_SRC_PIN: st_nxt.src_brg = 1'b0;
        dpw_pkg::CMD_FM:      st_nxt.fm      = 1'b1;
        dpw_pkg::CMD_NRZI:    st_nxt.fm      = 1'b0;
        default: ;                                 // null command
      endcase
    end

    // flags forced clear in nrzi or while disabled
    if (!st_nxt.fm || !st_nxt.en) begin
      st_nxt.one_miss  = 1'b0;
      st_nxt.two_miss  = 1'b0;
      st_nxt.miss_prev = 1'b0;
    end

    // clocks from the count; held count in search means no pulses
    tx_pos = st_nxt.cnt + dpw_pkg::POS_TX_LAG;
    if (st_nxt.fm) begin
      st_nxt.rxclk = st_nxt.cnt[dpw_pkg::BIT_FM_CK];
      st_nxt.txclk = tx_pos[dpw_pkg::BIT_FM_CK];
    end else begin
      st_nxt.rxclk = st_nxt.cnt[dpw_pkg::BIT_NRZI_CK];
      st_nxt.txclk = st_nxt.cnt[dpw_pkg::BIT_NRZI_CK];
    end

    // falling receive clock marks the sample point; with the
    // receiver in nrz this decodes manchester data
    st_nxt.samp = st_r.rxclk & ~st_nxt.rxclk;
  end

  // state register; reset disables, pin source, nrzi
  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_r          <= '0;
      st_r.search   <= 1'b1;
      st_r.cnt      <= dpw_pkg::POS_SEARCH;
      st_r.rxclk    <= 1'b1;
      st_r.txclk    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // registered outputs
  assign RDATA     = st_r.rd_v ? st_r.rdata : '0;
  assign RX_CLK    = st_r.rxclk;
  assign TX_CLK    = st_r.txclk;
  assign RX_SAMPLE = st_r.samp;

endmodule // dpw_top

// >>> tb/dpw_top_assertions.sv
`timescale 1ns/1ps
// port-level watch of the recovery loop and the diagnostic steering
module dpw_chk (
  input wire logic       CLK,
  input wire logic       SRST,
  input wire logic [1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       RXD_PIN,
  input wire logic       TXD_PIN,
  input wire logic       TX_DATA,
  input wire logic       RX_DATA,
  input wire logic       TX_GO,
  input wire logic       RX_GO,
  input wire logic       RX_CLK,
  input wire logic       TX_CLK,
  input wire logic       RX_SAMPLE
);
  logic [1:0] ctl_r;   // loop, echo as last written
  logic [2:0] age_r;   // cycles since control write, saturating
  logic       stat_r;  // RDATA now carries the status byte
  // shadow of the steering bits; the syncs need a few cycles to settle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ctl_r <= 2'h0;
      age_r <= 3'h0;
      stat_r <= 1'b0;
    end else begin
      stat_r <= RD && (ADDR == 2'h1);
      if (WR && (ADDR == 2'h0)) begin
        ctl_r <= WDATA[4:3];
        age_r <= 3'h0;
      end else if (age_r != 3'h7) begin
        age_r <= age_r + 3'h1;
      end
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside answer cycle");
  rst_dflt_a: assert property ($past(SRST) |-> RX_CLK && TX_CLK && !RX_SAMPLE)
    else $error("clock outputs not at reset level");
  miss_clear_a: assert property (stat_r && !(RDATA[2] && RDATA[0]) |-> RDATA[7:6] == 2'h0)
    else $error("miss flag set outside fm");
  miss_cmd_a: assert property ((WR && ADDR == 2'h0 && WDATA[7:5] == 3'h2)
    ##[1:2] (RD && ADDR == 2'h1) |=> RDATA[7:6] == 2'h0)
    else $error("miss flags survive reset command");
  search_low_a: assert property (stat_r && RDATA[2:0] == 3'h7 |-> !RX_CLK && !TX_CLK)
    else $error("clock pulse while searching");
  sample_fall_a: assert property ($fell(RX_CLK) |-> ##[0:1] RX_SAMPLE)
    else $error("no sample on falling receive clock");
  sample_low_a: assert property (RX_SAMPLE |-> !RX_CLK)
    else $error("sample while receive clock high");
  loop_route_a: assert property (age_r == 3'h7 && ctl_r == 2'h2
    |-> RX_DATA == $past(TX_DATA) && TXD_PIN == $past(TX_DATA))
    else $error("loopback routing wrong");
  loop_en_a: assert property (age_r == 3'h7 && ctl_r[1] |-> TX_GO && RX_GO)
    else $error("pin enables honoured in loopback");
  echo_route_a: assert property (age_r == 3'h7 && ctl_r[0] |-> TX_GO
    && TXD_PIN == $past(RXD_PIN, 3) && RX_DATA == $past(RXD_PIN, 3))
    else $error("echo routing wrong");
  two_miss_c: cover property (stat_r && RDATA[6]);
  loop_c: cover property (age_r == 3'h7 && ctl_r == 2'h2);
  echo_c: cover property (age_r == 3'h7 && ctl_r[0]);
endmodule // dpw_chk
bind dpw_top dpw_chk u_chk (.CLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .RXD_PIN, .TXD_PIN,
  .TX_DATA, .RX_DATA, .TX_GO, .RX_GO, .RX_CLK, .TX_CLK, .RX_SAMPLE);

// >>> tb/dpw_line_model.sv
`timescale 1ns/1ps
// far end: x16 source clock and an fm0 line sending ones
module dpw_line_model (
  input  wire logic CLK,
  input  wire logic SRST,
  input  wire logic RUN_EDGES,  // line keeps its cell edges
  output logic      SRC_PIN,    // one level change per half count
  output logic      RXD         // encoded line
);
  logic [5:0] tick_r;  // clk cycles in one cell of 16 source periods
  // only boundary edges, so search never locks to data edges
  always_ff @(posedge CLK) begin
    if (SRST) begin
      tick_r <= 6'h00;
      RXD <= 1'b1;
    end else begin
      tick_r <= tick_r + 6'h01;
      if (tick_r == 6'h3f && RUN_EDGES) RXD <= ~RXD;
    end
  end
  assign SRC_PIN = tick_r[1];  // source runs free, as a clock pin does
endmodule // dpw_line_model

// >>> tb/dpw_top_tb.sv
`timescale 1ns/1ps
// bench for the recovery loop, miss flags and diagnostic paths
module dpw_top_tb;
  logic CLK = 1'b0, SRST = 1'b1, WR = 1'b0, RD = 1'b0, TX_DATA = 1'b0;
  logic CTS_N = 1'b1, DCD_N = 1'b1, AUTO = 1'b1, edges = 1'b1;
  logic [1:0] ADDR = 2'h0;
  logic [7:0] WDATA = 8'h00, RDATA, rd_v;
  logic TXD_PIN, RX_DATA, TX_GO, RX_GO, RX_CLK, TX_CLK, RX_SAMPLE, src, rxd;
  int failures = 0;
  int n_compared = 0;
  dpw_top u_dut (.CLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .RX_TX_CLOCK_PIN(src),
    .BRG_CLK(1'b0), .RXD_PIN(rxd), .TXD_PIN, .TX_DATA, .RX_DATA,
    .CLEAR_TO_SEND_PIN_N(CTS_N), .CARRIER_DETECT_PIN_N(DCD_N), .AUTO_ENABLES(AUTO),
    .TX_GO, .RX_GO, .RX_CLK, .TX_CLK, .RX_SAMPLE);
  dpw_line_model u_line (.CLK, .SRST, .RUN_EDGES(edges), .SRC_PIN(src), .RXD(rxd));
  // transmit side runs off this free clock, never the loop outputs
  initial forever #10 CLK = ~CLK;
  task automatic close_out;
    if (failures == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle strobes; read data taken in the cycle after the strobe
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge CLK) {WR, ADDR, WDATA} <= {1'b1, a, d};
    @(posedge CLK) WR <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge CLK) {RD, ADDR} <= {1'b1, a};
    @(posedge CLK) RD <= 1'b0;
    #1 rd_v = RDATA;
  endtask
  // bounded poll of one status bit
  task automatic wait_stat(input int b, input logic v);
    repeat (2000) begin
      rd(2'h1);
      if (rd_v[b] === v) break;
    end
  endtask
  // falling receive clocks over one full fm count cycle of 64 ticks
  task automatic count_samp;
    int n = 0;
    repeat (128) begin
      @(posedge CLK) #1;
      n += int'(RX_SAMPLE);
    end
    chk(n[7:0], 8'h02);
  endtask
  task automatic settle;
    repeat (6) @(posedge CLK);
    #1;
  endtask
  task automatic t_reset;
    rd(2'h1); chk(rd_v, 8'h02);
    chk({RX_CLK, TX_CLK, RX_SAMPLE}, 3'h6);
    wr(2'h2, 8'hff); rd(2'h2); chk(rd_v, 8'h00);
    rd(2'h0); chk(rd_v, 8'h00);
  endtask
  task automatic t_fm;
    wr(2'h0, 8'ha0); wr(2'h0, 8'hc0); wr(2'h0, 8'h20);
    rd(2'h1); chk(rd_v & 8'hfd, 8'h05);
    wait_stat(1, 1'b0); chk(rd_v, 8'h05);
    count_samp;
    edges <= 1'b0;
    wait_stat(7, 1'b1); chk(rd_v, 8'h85);
    wait_stat(6, 1'b1); chk(rd_v, 8'hc5);
    wait_stat(1, 1'b1); chk(rd_v, 8'hc7);
    chk({RX_CLK, TX_CLK}, 2'h0);
    wr(2'h0, 8'h40); rd(2'h1); chk(rd_v, 8'h07);
    edges <= 1'b1;
    wait_stat(1, 1'b0);
    edges <= 1'b0;
    wait_stat(7, 1'b1);
    wr(2'h0, 8'he0); rd(2'h1); chk(rd_v & 8'hc4, 8'h00);
    wr(2'h0, 8'h60); wr(2'h0, 8'h80); rd(2'h1); chk(rd_v, 8'h0a);
    wr(2'h0, 8'ha0); rd(2'h1); chk(rd_v, 8'h02);
  endtask
  task automatic t_diag;
    for (int i = 0; i < 2; i++) begin
      wr(2'h0, 8'h10);
      @(posedge CLK) TX_DATA <= i[0];
      settle; chk({TXD_PIN, RX_DATA, TX_GO, RX_GO}, {TX_DATA, TX_DATA, 2'h3});
    end
    wr(2'h0, 8'h08);
    @(posedge CLK) TX_DATA <= ~rxd;
    settle; chk({TXD_PIN, RX_DATA, TX_GO}, {rxd, rxd, 1'b1});
    rd(2'h0); chk(rd_v, 8'h08);
    wr(2'h0, 8'h18);
    settle; chk({TXD_PIN, RX_DATA, TX_GO, RX_GO}, {rxd, rxd, 2'h3});
    rd(2'h0); chk(rd_v, 8'h18);
    wr(2'h0, 8'h00);
    settle; chk({TX_GO, RX_GO}, 8'h00);
  endtask
  initial begin
    repeat (2) @(posedge CLK);
    SRST <= 1'b0;
    t_reset;
    t_fm;
    t_diag;
    close_out;
  end
  // watchdog well past the longest poll sequence
  initial begin
    #1000000;
    failures++;
    close_out;
  end
endmodule // dpw_top_tb
